// [hw/gate_seq_consts.vh]
`ifndef GATE_SEQ_CONSTS_VH
`define GATE_SEQ_CONSTS_VH
// register byte offsets
`define OFF_REGULAR_TIMING 12'h000
`define OFF_SAFE_TIMING 12'h004
`define OFF_CONTROL 12'h008
`define OFF_CONFIG 12'h00c
`define OFF_CONFIG_TWO 12'h010
`define OFF_CLAMP_TIMING 12'h014
`define OFF_STATUS 12'h018
// reset values
`define RST_DELAY 8'h00
`define RST_LEVEL 4'h0
`define RST_CLAMP 8'h01
// field positions
`define LEVEL_LSB 8
`define CFG_COMP_OFF 0
`define CFG_SUPP_EN 1
`define CFG2_COMP_ON 0
`define CFG2_CLAMP_MODE 1
`define CFG2_ON_LSB 8
// special field values
`define DELAY_OFF 8'h00
`define CLAMP_ALWAYS_HIGH 8'h00
`define CLAMP_ALWAYS_LOW 8'hff
// extra start-stop cycles for short pulses
`define SS_EXTRA 8'h02
`endif

// [hw/gate_switching_sequencer.v]
`timescale 1ns/10ps
`include "gate_seq_consts.vh"

// Function
// - regular off delay from its field; zero disables regular two-level off
// - safe turn-off delay from safe field; zero disables safe two-level off
// - two-level off ramps to plateau, holds for delay, then hard commutation
// - safe sequences timed on main clock, regular on start-stop clock
// - regular delay delays pwm; short pulses stretched to delay width
// - off compensation bit lowers off plateau target by one junction drop
// - two-level on active with non-zero delay; plateau, hold, full voltage
// - on plateau level updatable while running; suitable value gives hard on
// - two-level on does not delay pwm; short pulses stretched to delay
// - on compensation bit raises on plateau target by one junction drop
// - two-level on and two-level off work together in one cycle
// - suppressor needs regular delay above 2; samples pwm each tick, aborts
// - after abort, new valid on command starts fresh turn-on
// - suppressor filters only turn-on pulses, never turn-off
// - valid turn-on waits regular delay then drives on, releases off
// - on plateau lasts the on delay field in start-stop ticks, the first one partial
// - safe set only for saturation or overcurrent faults, else regular
// - turn-off deasserts clamp disable, then ramps outputs at fixed slope
// - turn-off runs to completion with delays captured at its start
// - clamp disable stays low for clamp time after hard commutation
// - safe-only clamp mode deasserts only in safe off, time plus plateau
// - clamp time zero holds output high; all ones holds it low
// - gate monitor timeout restarted at every turn-on and turn-off
module gate_switching_sequencer #(
   parameter DW = 8,
   parameter LW = 4
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire pwm_command_pin,
   input wire main_secondary_clock,
   input wire start_stop_clock,
   input wire collector_saturation_fault,
   input wire overcurrent_trip,
   input wire other_off_request,
   input wire plateau_reached,
   output reg gate_on_drive,
   output reg gate_off_drive,
   output reg slow_slope,
   output reg on_plateau,
   output reg off_plateau,
   output reg [LW-1:0] plateau_level,
   output reg junction_comp,
   output reg clamp_disable_out,
   output reg monitor_restart
);

////////////////////////////////////////////////////////////////////////////
// sequence states; the off states keep their captured parameters
localparam S_OFF = 3'd0;
localparam S_ON_WAIT = 3'd1;
localparam S_ON_PLAT = 3'd2;
localparam S_ON = 3'd3;
localparam S_OFF_RAMP = 3'd4;
localparam S_OFF_HOLD = 3'd5;
localparam S_OFF_DONE = 3'd6;

reg [DW-1:0] regular_off_delay;
reg [DW-1:0] safe_off_delay;
reg [LW-1:0] regular_off_plateau_level;
reg [LW-1:0] safe_off_plateau_level;
reg [LW-1:0] on_plateau_level;
reg [DW-1:0] on_plateau_delay;
reg [DW-1:0] clamp_hold_time;
reg comp_off;
reg comp_on;
reg suppressor_enable;
reg clamp_safe_only_mode;

reg [2:0] state_reg;
reg [DW+1:0] cnt_reg;
reg [DW-1:0] cap_delay_reg;
reg cap_safe_reg;
reg [DW:0] clamp_cnt_reg;
reg clamping_reg;
reg ss_d_reg;
reg main_d_reg;
reg [31:0] rdata_reg;

wire ss_tick = start_stop_clock & ~ss_d_reg;
wire main_tick = main_secondary_clock & ~main_d_reg;
// only the two fault inputs pick the safe parameter set
wire fault_off = collector_saturation_fault | overcurrent_trip;
wire off_cmd = ~pwm_command_pin | other_off_request | fault_off;
wire wr = psel & penable & pwrite;
wire seq_tick = cap_safe_reg ? main_tick : ss_tick;
wire on_phase = state_reg == S_ON_PLAT || state_reg == S_ON;

// saturating level offset by one step (one junction drop)
function [LW-1:0] adj;
   input [LW-1:0] lvl;
   input up;
   input en;
   begin
      if (!en)
         adj = lvl;
      else if (up)
         adj = (&lvl) ? lvl : lvl + {{(LW-1){1'b0}}, 1'b1};
      else
         adj = (lvl == {LW{1'b0}}) ? lvl : lvl - {{(LW-1){1'b0}}, 1'b1};
   end
endfunction

// true on the lim-th tick counted; the first tick may end a partial cycle
function last_tick;
   input [DW-1:0] cnt;
   input [DW-1:0] lim;
   begin
      last_tick = (cnt + {{(DW-1){1'b0}}, 1'b1}) >= lim;
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// apb slave: zero wait states, unmapped offsets read zero and error
wire mapped = (paddr == `OFF_REGULAR_TIMING) || (paddr == `OFF_SAFE_TIMING)
   || (paddr == `OFF_CONTROL) || (paddr == `OFF_CONFIG)
   || (paddr == `OFF_CONFIG_TWO) || (paddr == `OFF_CLAMP_TIMING)
   || (paddr == `OFF_STATUS);
assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;
// read data is latched in the setup cycle and stands through the access
assign prdata = rdata_reg;

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      regular_off_delay <= `RST_DELAY;
      safe_off_delay <= `RST_DELAY;
      regular_off_plateau_level <= `RST_LEVEL;
      safe_off_plateau_level <= `RST_LEVEL;
      on_plateau_level <= `RST_LEVEL;
      on_plateau_delay <= `RST_DELAY;
      clamp_hold_time <= `RST_CLAMP;
      comp_off <= 1'b0;
      comp_on <= 1'b0;
      suppressor_enable <= 1'b0;
      clamp_safe_only_mode <= 1'b0;
   end else if (clk_en && wr) begin
      case (paddr)
         `OFF_REGULAR_TIMING: regular_off_delay <= pwdata[DW-1:0];
         `OFF_SAFE_TIMING: begin
            safe_off_delay <= pwdata[DW-1:0];
            safe_off_plateau_level <= pwdata[`LEVEL_LSB+LW-1:`LEVEL_LSB];
         end
         `OFF_CONTROL: begin
            regular_off_plateau_level <= pwdata[LW-1:0];
            on_plateau_level <= pwdata[`LEVEL_LSB+LW-1:`LEVEL_LSB];
         end
         `OFF_CONFIG: begin
            comp_off <= pwdata[`CFG_COMP_OFF];
            suppressor_enable <= pwdata[`CFG_SUPP_EN];
         end
         `OFF_CONFIG_TWO: begin
            comp_on <= pwdata[`CFG2_COMP_ON];
            clamp_safe_only_mode <= pwdata[`CFG2_CLAMP_MODE];
            on_plateau_delay <= pwdata[`CFG2_ON_LSB+DW-1:`CFG2_ON_LSB];
         end
         `OFF_CLAMP_TIMING: clamp_hold_time <= pwdata[DW-1:0];
         default: ;
      endcase
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn)
      rdata_reg <= 32'h0;
   else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
         `OFF_REGULAR_TIMING: rdata_reg <= {{(32-DW){1'b0}},
            regular_off_delay};
         `OFF_SAFE_TIMING: rdata_reg <= {{(24-LW){1'b0}},
            safe_off_plateau_level, safe_off_delay};
         `OFF_CONTROL: rdata_reg <= {{(24-LW){1'b0}}, on_plateau_level,
            {(8-LW){1'b0}}, regular_off_plateau_level};
         `OFF_CONFIG: rdata_reg <= {30'h0, suppressor_enable, comp_off};
         `OFF_CONFIG_TWO: rdata_reg <= {{(24-DW){1'b0}}, on_plateau_delay,
            6'h0, clamp_safe_only_mode, comp_on};
         `OFF_CLAMP_TIMING: rdata_reg <= {{(32-DW){1'b0}}, clamp_hold_time};
         `OFF_STATUS: rdata_reg <= {24'h0, clamp_disable_out, cap_safe_reg,
            gate_on_drive, gate_off_drive, 1'b0, state_reg};
         default: rdata_reg <= 32'h0;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// oscillators are sampled inputs; one tick per rising edge
// they are taken as synchronous to pclk, so no synchroniser is fitted
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ss_d_reg <= 1'b0;
      main_d_reg <= 1'b0;
   end else if (clk_en) begin
      ss_d_reg <= start_stop_clock;
      main_d_reg <= main_secondary_clock;
   end
end

////////////////////////////////////////////////////////////////////////////
// switching sequence
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      state_reg <= S_OFF;
      cnt_reg <= {(DW+2){1'b0}};
      cap_delay_reg <= `RST_DELAY;
      cap_safe_reg <= 1'b0;
      monitor_restart <= 1'b0;
      clamping_reg <= 1'b0;
   end else if (clk_en) begin
      monitor_restart <= 1'b0;
      case (state_reg)
         S_OFF: begin
            cap_safe_reg <= 1'b0;
            // fresh on command after any abort starts anew
            if (!off_cmd) begin
               state_reg <= S_ON_WAIT;
               cnt_reg <= {(DW+2){1'b0}};
            end
         end
         S_ON_WAIT: begin
            // only turn-on is filtered; faults still win
            if (fault_off || other_off_request) begin
               state_reg <= S_OFF;
            end else if (suppressor_enable && ss_tick
                  && !pwm_command_pin) begin
               state_reg <= S_OFF;
            end else if (!suppressor_enable && regular_off_delay == 
                  `DELAY_OFF) begin
               state_reg <= S_ON_PLAT;
               cnt_reg <= {(DW+2){1'b0}};
               monitor_restart <= 1'b1;
            end else if (ss_tick) begin
               if (last_tick(cnt_reg[DW-1:0], regular_off_delay)) begin
                  state_reg <= S_ON_PLAT;
                  cnt_reg <= {(DW+2){1'b0}};
                  monitor_restart <= 1'b1;
               end else
                  cnt_reg <= cnt_reg + 1'b1;
            end
         end
         S_ON_PLAT: begin
            // plateau counted from plateau entry on start-stop ticks,
            // pwm not re-sampled so short pulses stretch
            if (fault_off) begin
               state_reg <= S_OFF_RAMP;
               cap_safe_reg <= 1'b1;
               cap_delay_reg <= safe_off_delay;
               monitor_restart <= 1'b1;
            end else if (on_plateau_delay == `DELAY_OFF)
               state_reg <= S_ON;
            else if (ss_tick) begin
               if (last_tick(cnt_reg[DW-1:0], on_plateau_delay))
                  state_reg <= S_ON;
               else
                  cnt_reg <= cnt_reg + 1'b1;
            end
         end
         S_ON: begin
            if (off_cmd) begin
               state_reg <= S_OFF_RAMP;
               cnt_reg <= {(DW+2){1'b0}};
               monitor_restart <= 1'b1;
               cap_safe_reg <= fault_off;
               // delay and safe/regular set choice frozen for the whole off sequence
               cap_delay_reg <= fault_off ? safe_off_delay
                  : regular_off_delay;
            end
         end
         S_OFF_RAMP: begin
            if (cap_delay_reg == `DELAY_OFF)
               state_reg <= S_OFF_DONE;
            else if (plateau_reached) begin
               state_reg <= S_OFF_HOLD;
               cnt_reg <= {(DW+2){1'b0}};
            end
         end
         S_OFF_HOLD: begin
            if (seq_tick) begin
               if (last_tick(cnt_reg[DW-1:0], cap_delay_reg)) begin
                  state_reg <= S_OFF_DONE;
                  // the extra start-stop count below starts from zero
                  cnt_reg <= {(DW+2){1'b0}};
               end else
                  cnt_reg <= cnt_reg + 1'b1;
            end
         end
         S_OFF_DONE: begin
            // regular off: extra start-stop cycles bound the min pulse
            if (cap_safe_reg || cap_delay_reg == `DELAY_OFF)
               state_reg <= S_OFF;
            else if (ss_tick) begin
               if (last_tick(cnt_reg[DW-1:0], `SS_EXTRA))
                  state_reg <= S_OFF;
               else
                  cnt_reg <= cnt_reg + 1'b1;
            end
         end
         default: state_reg <= S_OFF;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// clamp disable timing on seq_tick, which falls back to start-stop ticks once S_OFF clears cap_safe_reg
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      clamp_cnt_reg <= {(DW+1){1'b0}};
      clamp_disable_out <= 1'b1;
   end else if (clk_en) begin
      if (clamp_hold_time == `CLAMP_ALWAYS_HIGH)
         clamp_disable_out <= 1'b1;
      else if (clamp_hold_time == `CLAMP_ALWAYS_LOW)
         clamp_disable_out <= 1'b0;
      // a fault on the on plateau is a turn-off too and arms the clamp
      else if (((state_reg == S_ON && off_cmd)
            || (state_reg == S_ON_PLAT && fault_off))
            && (!clamp_safe_only_mode || fault_off)) begin
         clamp_disable_out <= 1'b0;
         clamp_cnt_reg <= {(DW+1){1'b0}};
      end else if (!clamp_disable_out && state_reg != S_OFF_RAMP
            && state_reg != S_OFF_HOLD && seq_tick) begin
         // runs from hard commutation on
         if (last_tick(clamp_cnt_reg[DW-1:0], clamp_hold_time))
            clamp_disable_out <= 1'b1;
         else
            clamp_cnt_reg <= clamp_cnt_reg + 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// output stage commands
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      gate_on_drive <= 1'b0;
      gate_off_drive <= 1'b1;
      slow_slope <= 1'b0;
      on_plateau <= 1'b0;
      off_plateau <= 1'b0;
      plateau_level <= {LW{1'b0}};
      junction_comp <= 1'b0;
   end else if (clk_en) begin
      gate_on_drive <= on_phase;
      gate_off_drive <= !on_phase;
      slow_slope <= state_reg == S_OFF_RAMP;
      // with a zero on delay the plateau state lasts one cycle; hide it
      on_plateau <= state_reg == S_ON_PLAT
         && on_plateau_delay != `DELAY_OFF;
      off_plateau <= state_reg == S_OFF_RAMP || state_reg == S_OFF_HOLD;
      if (state_reg == S_ON_PLAT) begin
         plateau_level <= adj(on_plateau_level, 1'b1, comp_on);
         junction_comp <= comp_on;
      end else begin
         plateau_level <= adj(cap_safe_reg ? safe_off_plateau_level
            : regular_off_plateau_level, 1'b0, comp_off);
         junction_comp <= comp_off;
      end
   end
end

endmodule

// [verif/gate_seq_chk.sv]
`timescale 1ns/10ps
`include "gate_seq_consts.vh"
module gate_seq_chk (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pslverr,
   input wire gate_on_drive,
   input wire gate_off_drive,
   input wire on_plateau,
   input wire clamp_disable_out,
   input wire monitor_restart
);
   reg [7:0] hold_reg;
   reg [7:0] hold_old;
   // two-deep shadow so a fresh write has settled before it is judged
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= `RST_CLAMP;
         hold_old <= `RST_CLAMP;
      end else if (clk_en) begin
         hold_old <= hold_reg;
         if (psel && penable && pwrite && paddr == `OFF_CLAMP_TIMING) begin
            hold_reg <= pwdata[7:0];
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SLVERR: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   AST_RST_OUT: assert property ($rose(presetn) |->
      gate_off_drive && clamp_disable_out && !gate_on_drive)
      else $error("outputs not at reset levels");
   AST_MON_PULSE: assert property (
      monitor_restart && clk_en |=> !monitor_restart)
      else $error("monitor restart longer than one cycle");
   AST_ON_RELEASE: assert property (
      $rose(gate_on_drive) |-> !gate_off_drive)
      else $error("off drive not released at turn-on");
   AST_ON_PLATEAU: assert property (on_plateau |-> gate_on_drive)
      else $error("on plateau without on drive");
   AST_FREEZE: assert property (!clk_en |=>
      $stable({gate_on_drive, gate_off_drive, clamp_disable_out}))
      else $error("outputs moved while clock enable low");
   AST_CLAMP_HIGH: assert property (
      hold_reg == `CLAMP_ALWAYS_HIGH && hold_old == `CLAMP_ALWAYS_HIGH
      |-> clamp_disable_out)
      else $error("clamp disable low with zero clamp time");
   AST_CLAMP_LOW: assert property (
      hold_reg == `CLAMP_ALWAYS_LOW && hold_old == `CLAMP_ALWAYS_LOW
      |-> !clamp_disable_out)
      else $error("clamp disable high with all-ones clamp time");
endmodule
bind gate_switching_sequencer gate_seq_chk u_gate_seq_chk (.*);

// [verif/gate_booster_model.sv]
`timescale 1ns/10ps
module gate_booster_model (
   input wire pclk,
   input wire presetn,
   input wire slow_slope,
   input wire off_plateau,
   input wire [2:0] ramp_len,
   output logic plateau_reached
);
   logic [2:0] cnt;
   // gate only sits at the plateau while ramping down or held there
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
         plateau_reached <= 1'b0;
      end else if (!slow_slope && !off_plateau) begin
         cnt <= 3'h0;
         plateau_reached <= 1'b0;
      end else begin
         if (cnt != ramp_len) begin
            cnt <= cnt + 3'h1;
         end
         plateau_reached <= cnt == ramp_len;
      end
   end
endmodule

// [verif/gate_switching_sequencer_bench.sv]
`timescale 1ns/10ps
`include "gate_seq_consts.vh"
module gate_switching_sequencer_bench;
   localparam int SS = 4;
   localparam int MS = 6;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic pwm_command_pin, main_secondary_clock, start_stop_clock;
   logic collector_saturation_fault, overcurrent_trip, other_off_request;
   logic plateau_reached, gate_on_drive, gate_off_drive, slow_slope;
   logic on_plateau, off_plateau, junction_comp, clamp_disable_out;
   logic monitor_restart, serr, mon_seen, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] plateau_level, lvl_on, lvl_off, prev;
   logic [2:0] ramp_len;
   int cyc = 0;
   int errors = 0;
   int n_compared = 0;
   int t_st, t_cmd, t_on, t_off, t_cl, t_p0, t_p1, dr, ds, src, z, seed;

   gate_switching_sequencer u_gate_switching_sequencer (.*);
   gate_booster_model u_gate_booster_model (.*);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      start_stop_clock <= (cyc % SS) < SS / 2;
      main_secondary_clock <= (cyc % MS) < MS / 2;
      prev <= {gate_on_drive, off_plateau, clamp_disable_out, on_plateau};
      if (gate_on_drive === 1'b1 && prev[3] === 1'b0) t_on <= cyc;
      // hard commutation is where the off plateau ends
      if (off_plateau === 1'b0 && prev[2] === 1'b1) t_off <= cyc;
      if (clamp_disable_out === 1'b0 && prev[1] === 1'b1) t_cl <= cyc;
      if (on_plateau === 1'b1 && prev[0] === 1'b0) t_p0 <= cyc;
      if (on_plateau === 1'b0 && prev[0] === 1'b1) t_p1 <= cyc;
      if (monitor_restart === 1'b1) mon_seen <= 1'b1;
      if (off_plateau === 1'b1) lvl_off <= plateau_level;
      if (on_plateau === 1'b1) lvl_on <= plateau_level;
      if (cyc == 10000) begin
         errors = errors + 1;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////
   function automatic logic in_rng(int v, int lo, int hi);
      return v >= lo && v <= hi;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, got);
      n_compared++;
      if (e !== got) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count is assumed; only the bench timeout ends this
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // on command for w cycles, then the chosen off source
   task automatic pulse(input int w, input int s);
      int n;
      t_on = -1;
      t_off = -1;
      t_cl = -1;
      mon_seen = 1'b0;
      t_st = cyc;
      ramp_len <= 3'(1 + $urandom % 4);
      pwm_command_pin <= 1'b1;
      repeat (w) @(posedge pclk);
      t_cmd = cyc;
      case (s)
         0: pwm_command_pin <= 1'b0;
         1: other_off_request <= 1'b1;
         2: collector_saturation_fault <= 1'b1;
         default: overcurrent_trip <= 1'b1;
      endcase
      n = 0;
      while (t_off < t_cmd && n < 400 && (t_on >= 0 || n < 80)) begin
         @(posedge pclk);
         n++;
      end
      pwm_command_pin <= 1'b0;
      other_off_request <= 1'b0;
      collector_saturation_fault <= 1'b0;
      overcurrent_trip <= 1'b0;
      repeat (30) @(posedge pclk);
   endtask
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {presetn, clk_en, psel, penable, pwrite, pwm_command_pin} = 6'h10;
      {collector_saturation_fault, overcurrent_trip} = 2'h0;
      {other_off_request, main_secondary_clock, start_stop_clock} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ramp_len = 3'h2;
      seed = $urandom(70);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFF_CLAMP_TIMING, 32'h0);
      chk("clamp_reset", {24'h0, `RST_CLAMP}, rd);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, serr});
      clk_en <= 1'b0;
      repeat (4) @(posedge pclk);
      clk_en <= 1'b1;
      for (z = 0; z < 3; z++) begin
         dr = z == 0 ? 0 : 3 + $urandom % 2;
         ds = z == 0 ? 0 : 6 + $urandom % 3;
         apb(1'b1, `OFF_REGULAR_TIMING, 32'(dr));
         apb(1'b1, `OFF_SAFE_TIMING, 32'(ds));
         apb(1'b1, `OFF_CONFIG_TWO, z == 2 ? 32'h0302 : 32'h0);
         apb(1'b0, `OFF_SAFE_TIMING, 32'h0);
         chk("safe_timing", 32'(ds), rd);
         for (src = 0; src < 4; src++) begin
            pulse(60, src);
            ok = in_rng(t_on - t_st, (dr - 1) * SS, dr * SS + 4);
            chk("on_latency", 1, ok);
            ok = src < 2 ? in_rng(t_off - t_cmd, (dr - 1) * SS, dr * SS + 12)
                         : in_rng(t_off - t_cmd, (ds - 1) * MS, ds * MS + 12);
            chk("off_time", 1, ok);
            chk("clamp_fall", z != 2 || src > 1, t_cl >= 0);
            chk("monitor", 1, mon_seen);
            chk("off_drive", 1, gate_off_drive);
            chk("clamp_back", 1, clamp_disable_out);
         end
      end
      apb(1'b1, `OFF_CONFIG_TWO, 32'h0);
      apb(1'b1, `OFF_REGULAR_TIMING, 32'h4);
      pulse(2, 0);
      chk("short_stretch", 1, t_off - t_on >= 3 * SS);
      apb(1'b1, `OFF_CONFIG, 32'h2);
      pulse(2, 0);
      chk("suppressed", 1, t_on < 0);
      pulse(60, 0);
      chk("fresh_on", 1, t_on >= 0);
      apb(1'b1, `OFF_CONTROL, 32'h0a05);
      apb(1'b1, `OFF_CONFIG, 32'h1);
      apb(1'b1, `OFF_CONFIG_TWO, 32'h0301);
      pulse(40, 1);
      chk("junction_comp", 1, junction_comp);
      chk("off_level", 32'h4, {28'h0, lvl_off});
      chk("on_level", 32'hb, {28'h0, lvl_on});
      apb(1'b1, `OFF_CONFIG, 32'h0);
      apb(1'b1, `OFF_REGULAR_TIMING, 32'h0);
      apb(1'b1, `OFF_CONFIG_TWO, 32'h0500);
      pulse(2, 0);
      chk("on_stretch", 1, t_off - t_on >= 4 * SS);
      chk("on_plateau", 1, in_rng(t_p1 - t_p0, 4 * SS, 5 * SS));
      apb(1'b1, `OFF_CLAMP_TIMING, {24'h0, `CLAMP_ALWAYS_HIGH});
      pulse(30, 0);
      chk("clamp_never", 1, t_cl < 0);
      apb(1'b1, `OFF_CLAMP_TIMING, {24'h0, `CLAMP_ALWAYS_LOW});
      pulse(30, 2);
      chk("clamp_always", 0, clamp_disable_out);
      finish_test();
   end
endmodule
